// *** hdl/mmssu_pkg.sv ***
package mmssu_pkg;

  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_BUF = 8'h04;
  localparam logic [7:0] ADDR_BAUD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_MASK = 8'h10;

  // control register fields
  localparam int CTRL_MODE0 = 0;
  localparam int CTRL_MODE1 = 1;
  localparam int CTRL_OVR = 2;
  localparam int CTRL_END = 3;
  localparam int CTRL_RXSEL = 4;
  localparam int CTRL_RUN = 5;
  localparam int CTRL_ORDER = 6;
  localparam int CTRL_IE = 7;
  localparam int CTRL_CLKINT = 8;
  localparam int CTRL_TWOWIRE = 9;

  // interrupt status fields
  localparam int STAT_END = 0;
  localparam int STAT_OVR = 1;

  // values after reset
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [8:0] BUF_RST = 9'h000;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;

  // log2 of the shift clock period per reload step, in cycles
  localparam int SYNC_STEP_LOG2 = 1;
  localparam int UART_STEP_LOG2 = 3;

  // bit counts of a frame
  localparam logic [3:0] DATA_LAST = 4'h8;
  localparam logic [3:0] NINTH = 4'h9;
  localparam logic [3:0] UART_PRESTART = 4'hF;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MMSSU_SYNC = 2'h0,
    MMSSU_UART = 2'h1,
    MMSSU_MASTER = 2'h2,
    MMSSU_SLAVE = 2'h3
  } mmssu_mode_type;

  typedef enum logic [1:0] {
    MMSSU_IDLE = 2'b01,
    MMSSU_BUSY = 2'b10
  } mmssu_state_type;

endpackage

// *** hdl/mmssu_top.sv ***
`timescale 1ns/1ps
// Behaviour
// [RULE1] both mode bits zero: synchronous eight-bit clocked serial transfer
// [RULE2] mode_bit0 one, mode_bit1 zero: asynchronous UART operation
// [RULE3] software loads the baud reload counter when clock is internal
// [RULE4] clock pin drives out for internal clock, is input for external
// [RULE5] receive_select 1 for receive-only, 0 otherwise; two-wire is open-drain
// [RULE6] software writes outgoing byte to shift buffer with receive_select zero
// [RULE7] software setting run_flag starts an eight-bit transfer
// [RULE8] incoming data pin bits are captured on every transfer direction
// [RULE9] handler reads shift buffer and clears end_flag before leaving
// [RULE10] overrun on idle clock fall, completion with end set, slave start
// [RULE11] only a software write clears overrun_flag
// [RULE12] shift buffer copied into shifter at every start
// [RULE13] shifter to buffer bits 0-7 after eighth data bit
// [RULE14] bit 8: never in mode 0, stop bit mode 1, ninth clock 2/3
// [RULE15] shift clock 2 to 512 cycles, UART bit 8 to 2048 cycles
// [RULE16] at transfer end shifter lands in buffer low byte
// [RULE17] mode 2 bus master, mode 3 bus slave
// [RULE18] end_flag with interrupt_enable raises interrupt until end cleared
module mmssu_top #(
  parameter int ADDR_W = 8
) (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic clock_pin_i,
  output logic clock_pin_o,
  output logic clock_pin_oe_o,
  output logic data_out_pin_o,
  input wire logic data_io_pin_i,
  output logic data_io_pin_o,
  output logic data_io_pin_oe_o,
  output logic irq_o
);

  if (ADDR_W < 8) begin : g_addr_check
    $error("ADDR_W must be at least 8");
  end

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [9:0] ctrl;
  logic [8:0] shift_buffer;
  logic [7:0] baud_reload_counter;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] internal_shifter;
  logic [3:0] bit_cnt;
  logic [11:0] baud_timer;
  logic sclk_int;
  logic tx_bit;
  mmssu_pkg::mmssu_state_type state;
  logic [2:0] sck_sync;
  logic [2:0] dio_sync;
  logic aw_full, w_full;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire logic run_flag = ctrl[mmssu_pkg::CTRL_RUN];
  wire logic end_flag = ctrl[mmssu_pkg::CTRL_END];
  wire logic overrun_flag = ctrl[mmssu_pkg::CTRL_OVR];
  wire logic receive_select = ctrl[mmssu_pkg::CTRL_RXSEL];
  wire logic bit_order_select = ctrl[mmssu_pkg::CTRL_ORDER];
  wire logic interrupt_enable = ctrl[mmssu_pkg::CTRL_IE];
  mmssu_pkg::mmssu_mode_type mode;
  assign mode = mmssu_pkg::mmssu_mode_type'({ctrl[mmssu_pkg::CTRL_MODE1],
                                             ctrl[mmssu_pkg::CTRL_MODE0]});

  // ---------------------------------------------------------------
  // pin synchronisers and edge detection
  // ---------------------------------------------------------------
  // stage 0 feeds stage 1 only; edges come from stages 1 and 2
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sck_sync <= 3'h7;
      dio_sync <= 3'h7;
    end else if (ce_i) begin
      sck_sync <= {sck_sync[1:0], clock_pin_i};
      dio_sync <= {dio_sync[1:0], data_io_pin_i};
    end
  end

  wire logic din = dio_sync[1];
  wire logic ext_rise = sck_sync[1] & ~sck_sync[2];
  wire logic ext_fall = ~sck_sync[1] & sck_sync[2];
  wire logic dio_fall = ~dio_sync[1] & dio_sync[2];
  wire logic is_uart = (mode == mmssu_pkg::MMSSU_UART); // see [RULE2]
  wire logic clk_int_src = (mode == mmssu_pkg::MMSSU_MASTER) |
    ((mode == mmssu_pkg::MMSSU_SYNC) & ctrl[mmssu_pkg::CTRL_CLKINT]);
  wire logic busy = (state == mmssu_pkg::MMSSU_BUSY);

  // ---------------------------------------------------------------
  // register bus decode
  // ---------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old_v & ~m) | (new_v & m);
  endfunction

  wire logic wr_go = aw_full & w_full & ~s_axi_bvalid_o;
  wire logic [7:0] wr_addr = aw_addr[7:0];
  wire logic wr_hit = (aw_addr >> 8) == '0;
  wire logic wr_ctrl = wr_go & wr_hit & (wr_addr == mmssu_pkg::ADDR_CTRL);
  wire logic wr_buf = wr_go & wr_hit & (wr_addr == mmssu_pkg::ADDR_BUF);
  wire logic wr_baud = wr_go & wr_hit & (wr_addr == mmssu_pkg::ADDR_BAUD);
  wire logic wr_mask = wr_go & wr_hit & (wr_addr == mmssu_pkg::ADDR_MASK);
  wire logic wr_ok = wr_ctrl | wr_buf | wr_baud | wr_mask |
    (wr_hit & (wr_addr == mmssu_pkg::ADDR_STAT));
  wire logic [31:0] ctrl_wval = merge({22'h0, ctrl}, w_data, w_strb);
  wire logic [31:0] buf_wval = merge({23'h0, shift_buffer}, w_data, w_strb);
  wire logic [31:0] baud_wval =
    merge({24'h0, baud_reload_counter}, w_data, w_strb);
  wire logic [31:0] mask_wval = merge({30'h0, irq_mask}, w_data, w_strb);

  wire logic rd_go = s_axi_arvalid_i & s_axi_arready_o;
  wire logic rd_hit = (s_axi_araddr_i >> 8) == '0;
  wire logic [7:0] rd_addr = s_axi_araddr_i[7:0];
  wire logic rd_stat = rd_go & rd_hit & (rd_addr == mmssu_pkg::ADDR_STAT);

  // ---------------------------------------------------------------
  // transfer start, timing and events
  // ---------------------------------------------------------------
  wire logic sw_run_set = wr_ctrl & ctrl_wval[mmssu_pkg::CTRL_RUN] &
    ~run_flag; // see [RULE7]
  wire logic uart_auto = is_uart & ~run_flag & dio_fall;
  wire logic slave_start = (mode == mmssu_pkg::MMSSU_SLAVE) & dio_fall &
    sck_sync[1]; // see [RULE17]
  wire logic start_xfer = ~busy & (sw_run_set | uart_auto |
    (slave_start & ~run_flag & ~end_flag));
  wire logic [8:0] brg_p1 = {1'b0, baud_reload_counter} + 9'h001;
  wire logic [11:0] period_len = is_uart ?
    {brg_p1, 3'b000} : {2'b00, brg_p1, 1'b0}; // see [RULE15]
  wire logic [11:0] half_len = {1'b0, period_len[11:1]};
  wire logic timer_run = busy & (is_uart | clk_int_src);
  wire logic t_wrap = baud_timer == (period_len - 12'h001);
  wire logic t_half = baud_timer == (half_len - 12'h001);
  wire logic sh_rise = busy & (timer_run ? (is_uart ? t_half : t_wrap) :
    ext_rise);
  wire logic sh_fall = busy & (timer_run ? (is_uart ? t_wrap : t_half) :
    ext_fall);
  wire logic [3:0] next_cnt = bit_cnt + 4'h1;
  wire logic [7:0] next_shifter = bit_order_select ?
    {internal_shifter[6:0], din} : {din, internal_shifter[7:1]};
  wire logic sh_out = bit_order_select ? internal_shifter[7] :
    internal_shifter[0];
  wire logic done_ev = sh_rise & (((next_cnt == mmssu_pkg::DATA_LAST) &
    (mode == mmssu_pkg::MMSSU_SYNC)) | (next_cnt == mmssu_pkg::NINTH));
  wire logic ovr_set = (ext_fall & ~run_flag &
    (mode != mmssu_pkg::MMSSU_MASTER)) |
    (done_ev & end_flag) | slave_start; // see [RULE10]

  // baud timer runs only while an internal clock is needed
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud_timer <= 12'h000;
    end else if (ce_i) begin
      if (start_xfer || !timer_run || t_wrap) begin
        baud_timer <= 12'h000;
      end else begin
        baud_timer <= baud_timer + 12'h001;
      end
    end
  end

  // internal shift clock, idle high
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_int <= 1'b1;
    end else if (ce_i) begin
      if (!busy || is_uart) begin
        sclk_int <= 1'b1;
      end else if (sh_fall) begin
        sclk_int <= 1'b0;
      end else if (sh_rise) begin
        sclk_int <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // shift engine
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= mmssu_pkg::MMSSU_IDLE;
      bit_cnt <= 4'h0;
      internal_shifter <= 8'h00;
      tx_bit <= 1'b1;
    end else if (ce_i) begin
      case (state)
        mmssu_pkg::MMSSU_IDLE: begin
          tx_bit <= 1'b1;
          if (start_xfer) begin
            state <= mmssu_pkg::MMSSU_BUSY;
            internal_shifter <= shift_buffer[7:0]; // see [RULE12]
            if (is_uart) begin
              bit_cnt <= mmssu_pkg::UART_PRESTART;
              tx_bit <= receive_select; // start bit low on transmit
            end else begin
              bit_cnt <= 4'h0;
              tx_bit <= receive_select | (bit_order_select ?
                shift_buffer[7] : shift_buffer[0]); // see [RULE1]
            end
          end
        end
        mmssu_pkg::MMSSU_BUSY: begin
          if (!run_flag || done_ev) begin
            state <= mmssu_pkg::MMSSU_IDLE;
            tx_bit <= 1'b1;
          end else if (sh_rise) begin
            bit_cnt <= next_cnt;
            if (next_cnt != 4'h0 && next_cnt <= mmssu_pkg::DATA_LAST) begin
              internal_shifter <= next_shifter; // see [RULE8]
            end
          end else if (sh_fall) begin
            if (bit_cnt < mmssu_pkg::DATA_LAST) begin
              tx_bit <= receive_select | sh_out; // all ones on receive
            end else if (bit_cnt == mmssu_pkg::DATA_LAST) begin
              tx_bit <= ((mode == mmssu_pkg::MMSSU_MASTER) && receive_select)
                ? shift_buffer[8] : 1'b1;
            end
          end
        end
        default: begin
          state <= mmssu_pkg::MMSSU_IDLE;
        end
      endcase
    end
  end

  // shift buffer: software load, hardware result
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      shift_buffer <= mmssu_pkg::BUF_RST;
    end else if (ce_i) begin
      if (wr_buf) begin
        shift_buffer <= buf_wval[8:0]; // see [RULE6]
      end
      if (busy && sh_rise && run_flag) begin
        if (next_cnt == mmssu_pkg::DATA_LAST) begin
          shift_buffer[7:0] <= next_shifter; // see [RULE13] [RULE16]
        end
        if (next_cnt == mmssu_pkg::NINTH &&
            mode != mmssu_pkg::MMSSU_SYNC) begin
          shift_buffer[8] <= din; // see [RULE14]
        end
      end
    end
  end

  // control flags: hardware set wins over a software write
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ctrl <= mmssu_pkg::CTRL_RST;
    end else if (ce_i) begin
      if (wr_ctrl) begin
        ctrl <= ctrl_wval[9:0]; // see [RULE11]
      end
      if (start_xfer) begin
        ctrl[mmssu_pkg::CTRL_RUN] <= 1'b1;
      end else if (done_ev) begin
        ctrl[mmssu_pkg::CTRL_RUN] <= 1'b0;
      end
      if (done_ev) begin
        ctrl[mmssu_pkg::CTRL_END] <= 1'b1;
      end
      if (ovr_set) begin
        ctrl[mmssu_pkg::CTRL_OVR] <= 1'b1; // see [RULE10]
      end
    end
  end

  // baud reload value and interrupt registers
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      baud_reload_counter <= mmssu_pkg::BAUD_RST;
      irq_mask <= mmssu_pkg::MASK_RST;
      irq_status <= 2'h0;
    end else if (ce_i) begin
      if (wr_baud) begin
        baud_reload_counter <= baud_wval[7:0]; // see [RULE3]
      end
      if (wr_mask) begin
        irq_mask <= mask_wval[1:0];
      end
      irq_status[mmssu_pkg::STAT_END] <= done_ev |
        (irq_status[mmssu_pkg::STAT_END] & ~rd_stat);
      irq_status[mmssu_pkg::STAT_OVR] <= ovr_set |
        (irq_status[mmssu_pkg::STAT_OVR] & ~rd_stat);
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite slave
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= mmssu_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata_i;
        w_strb <= s_axi_wstrb_i;
      end
      if (wr_go) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? mmssu_pkg::RESP_OKAY : mmssu_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  assign s_axi_awready_o = ~aw_full & ~s_axi_bvalid_o;
  assign s_axi_wready_o = ~w_full & ~s_axi_bvalid_o;
  assign s_axi_arready_o = ~s_axi_rvalid_o;

  // read data mux; reading the status register clears it
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= 32'h0000_0000;
      s_axi_rresp_o <= mmssu_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (rd_go) begin
        s_axi_rvalid_o <= 1'b1;
        s_axi_rresp_o <= mmssu_pkg::RESP_OKAY;
        s_axi_rdata_o <= 32'h0000_0000;
        if (!rd_hit) begin
          s_axi_rresp_o <= mmssu_pkg::RESP_SLVERR;
        end else begin
          case (rd_addr)
            mmssu_pkg::ADDR_CTRL: s_axi_rdata_o <= {22'h0, ctrl};
            mmssu_pkg::ADDR_BUF: s_axi_rdata_o <= {23'h0, shift_buffer};
            mmssu_pkg::ADDR_BAUD: s_axi_rdata_o <= {24'h0, baud_reload_counter};
            mmssu_pkg::ADDR_STAT: s_axi_rdata_o <= {30'h0, irq_status};
            mmssu_pkg::ADDR_MASK: s_axi_rdata_o <= {30'h0, irq_mask};
            default: s_axi_rresp_o <= mmssu_pkg::RESP_SLVERR;
          endcase
        end
      end else if (s_axi_rready_i) begin
        s_axi_rvalid_o <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // pins and interrupt
  // ---------------------------------------------------------------
  assign clock_pin_o = sclk_int;
  assign clock_pin_oe_o = clk_int_src; // see [RULE4]
  assign data_out_pin_o = tx_bit;
  assign data_io_pin_o = 1'b0;
  assign data_io_pin_oe_o = ctrl[mmssu_pkg::CTRL_TWOWIRE] & ~tx_bit;
  assign irq_o = (end_flag & interrupt_enable) |
    (|(irq_status & irq_mask)); // see [RULE18]

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  logic [9:0] low_len;
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      low_len <= 10'h000;
    end else if (ce_i) begin
      low_len <= sclk_int ? 10'h000 : low_len + 10'h001;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  AST_OVR_CLEAR: assert property ($fell(overrun_flag) |-> $past(wr_ctrl)) // see [RULE11]
    else $error("overrun cleared without a write");
  AST_LOAD: assert property (ce_i && start_xfer |=>
    internal_shifter == $past(shift_buffer[7:0])) // see [RULE12]
    else $error("shifter not loaded at start");
  AST_BIT8_M0: assert property ($changed(shift_buffer[8]) &&
    $past(mode) == mmssu_pkg::MMSSU_SYNC |-> $past(wr_buf)) // see [RULE14]
    else $error("bit 8 moved in mode 0");
  AST_OVR_END: assert property (ce_i && done_ev && end_flag |=>
    overrun_flag) // see [RULE10]
    else $error("overrun missed on repeated completion");
  AST_CLK_IN: assert property (mode == mmssu_pkg::MMSSU_SYNC &&
    !ctrl[mmssu_pkg::CTRL_CLKINT] |-> !clock_pin_oe_o) // see [RULE4]
    else $error("clock pin driven with external clock");
  AST_IRQ: assert property (end_flag && interrupt_enable |-> irq_o) // see [RULE18]
    else $error("interrupt missing");
  AST_LOWBYTE: assert property (ce_i && busy && run_flag && sh_rise &&
    next_cnt == mmssu_pkg::DATA_LAST |=>
    shift_buffer[7:0] == $past(next_shifter)) // see [RULE13]
    else $error("low byte not stored");
  AST_UART_RX: assert property (ce_i && is_uart && !run_flag && !busy &&
    dio_fall |=> run_flag && busy) // see [RULE2]
    else $error("start bit not detected");
  AST_M0_EIGHT: assert property (done_ev && mode == mmssu_pkg::MMSSU_SYNC
    |-> next_cnt == 4'h8) // see [RULE1]
    else $error("mode 0 frame not eight clocks");
  AST_HALF_PERIOD: assert property (ce_i && timer_run && !is_uart &&
    $rose(sclk_int) |-> low_len == 10'(brg_p1)) // see [RULE15]
    else $error("shift clock low time wrong");

  COV_M0_DONE: cover property (done_ev && mode == mmssu_pkg::MMSSU_SYNC);
  COV_M1_DONE: cover property (done_ev && is_uart);
  COV_OVR: cover property ($rose(overrun_flag));
  COV_SLAVE: cover property (slave_start);

endmodule

// *** verif/mmssu_peer.sv ***
`timescale 1ns/1ps
// ---------------------------------------------------------------
// synchronous serial peer
// ---------------------------------------------------------------
module mmssu_peer (
  input wire logic line_clk_i,
  input wire logic dev_data_i,
  output logic ext_clk_o,
  output logic data_o
);
  logic [7:0] tx_byte;
  logic [7:0] rx_byte;
  int cnt;

  // load outgoing byte, bit 0 ready before the first fall
  task arm(input logic [7:0] b);
    tx_byte = b;
    cnt = 0;
    data_o = b[0];
  endtask

  // external clock burst, standing high between frames
  task burst(input int n);
    repeat (n) begin
      #100 ext_clk_o = 1'b0;
      #100 ext_clk_o = 1'b1;
    end
  endtask

  initial begin
    ext_clk_o = 1'b1;
    data_o = 1'b1;
    cnt = 8;
  end

  // take device bit on each rise, lsb first; spoil line after frame
  always @(posedge line_clk_i) begin
    if (cnt < 8) begin
      rx_byte[cnt] = dev_data_i;
      cnt = cnt + 1;
      if (cnt == 8) begin
        #60 data_o = ~data_o;
      end
    end
  end

  // next bit on each fall
  always @(negedge line_clk_i) begin
    if (cnt > 0 && cnt < 8) begin
      data_o = tx_byte[cnt];
    end
  end
endmodule

// *** verif/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, sys_rst_i = 1, ce_i = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, rdata;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic clk_o, clk_oe, dout, dio_o, dio_oe, irq, ext_clk, peer_data;
  logic [33:0] exp_q[$];
  logic [1:0] bq[$];
  logic [7:0] a, b, brg;
  int n_errors = 0, checks_done = 0, cyc = 0;
  time t_prev, t_last;
  wire line_clk = clk_oe ? clk_o : ext_clk;
  wire dio = dio_oe ? dio_o : peer_data;
  localparam logic [1:0] OK = mmssu_pkg::RESP_OKAY;

  initial begin
    forever #12.5 clk_i = ~clk_i;
  end

  mmssu_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
    .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
    .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
    .s_axi_rready_i(rready), .clock_pin_i(line_clk),
    .clock_pin_o(clk_o), .clock_pin_oe_o(clk_oe),
    .data_out_pin_o(dout), .data_io_pin_i(dio), .data_io_pin_o(dio_o),
    .data_io_pin_oe_o(dio_oe), .irq_o(irq));

  mmssu_peer peer (.line_clk_i(line_clk), .dev_data_i(dout),
    .ext_clk_o(ext_clk), .data_o(peer_data));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task chk(input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task report_and_stop;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // bus answers taken off the queues as they appear
  always @(posedge clk_i) begin
    if (rvalid === 1'b1 && rready === 1'b1) begin
      chk({rresp, rdata}, exp_q.pop_front());
    end
    if (bvalid === 1'b1 && bready === 1'b1) begin
      chk(bresp, bq.pop_front());
    end
  end

  // cycle ceiling and shift clock period capture
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop;
    end
  end
  always @(posedge clk_o) begin
    t_prev = t_last;
    t_last = $time;
  end

  // ---------------------------------------------------------------
  // bus tasks
  // ---------------------------------------------------------------
  task wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, pa, pw;
    bq.push_back(e);
    pa = 1;
    pw = 1;
    @(posedge clk_i);
    awaddr <= ad;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (pa || pw) begin
      @(negedge clk_i);
      ta = awvalid & awready;
      tw = wvalid & wready;
      @(posedge clk_i);
      if (ta) begin
        awvalid <= 0;
        pa = 0;
      end
      if (tw) begin
        wvalid <= 0;
        pw = 0;
      end
    end
    do @(negedge clk_i); while (bvalid !== 1'b1);
    @(posedge clk_i);
    bready <= 0;
  endtask

  task rd(input logic [7:0] ad, input logic [33:0] e);
    exp_q.push_back(e);
    @(posedge clk_i);
    araddr <= ad;
    arvalid <= 1;
    rready <= 1;
    do @(negedge clk_i); while (arready !== 1'b1);
    @(posedge clk_i);
    arvalid <= 0;
    do @(negedge clk_i); while (rvalid !== 1'b1);
    @(posedge clk_i);
    rready <= 0;
  endtask

  task wait_irq;
    int k;
    k = 0;
    while (irq !== 1'b1 && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    void'($urandom(20102));
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 0;
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h0});
    rd(8'h14, {mmssu_pkg::RESP_SLVERR, 32'h0});
    wr(8'h14, 32'hFFFFFFFF, mmssu_pkg::RESP_SLVERR);
    // every mode code, clock pin driven only as bus master
    for (int m = 0; m < 4; m++) begin
      wr(mmssu_pkg::ADDR_CTRL, 32'(m), OK);
      rd(mmssu_pkg::ADDR_CTRL, {OK, 32'(m)});
      chk(clk_oe, m == 2);
    end
    // internal clock transfer, transmit direction
    brg = 8'(3 + $urandom_range(4));
    a = 8'($urandom);
    b = 8'($urandom);
    wr(mmssu_pkg::ADDR_CTRL, 32'h0, OK);
    wr(mmssu_pkg::ADDR_BAUD, 32'(brg), OK);
    wr(mmssu_pkg::ADDR_BUF, {23'h0, 1'b1, a}, OK);
    peer.arm(b);
    wr(mmssu_pkg::ADDR_CTRL, 32'h1A0, OK);
    chk(clk_oe, 1);
    wait_irq;
    chk(irq, 1);
    chk(peer.rx_byte, a);
    chk(32'(t_last - t_prev), 32'(2 * (brg + 1) * 25));
    rd(mmssu_pkg::ADDR_BUF, {OK, 23'h0, 1'b1, b});
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h188});
    rd(mmssu_pkg::ADDR_STAT, {OK, 32'h1});
    rd(mmssu_pkg::ADDR_STAT, {OK, 32'h0});
    wr(mmssu_pkg::ADDR_CTRL, 32'h180, OK);
    repeat (2) @(posedge clk_i);
    chk(irq, 0);
    // two-wire idle: data line released, low level when pulled
    wr(mmssu_pkg::ADDR_CTRL, 32'h200, OK);
    chk({dio_oe, dio_o}, 0);
    // external clock transfer
    a = 8'($urandom);
    b = 8'($urandom);
    wr(mmssu_pkg::ADDR_BUF, {24'h0, a}, OK);
    peer.arm(b);
    wr(mmssu_pkg::ADDR_CTRL, 32'h0A0, OK);
    chk(clk_oe, 0);
    peer.burst(8);
    wait_irq;
    chk(peer.rx_byte, a);
    rd(mmssu_pkg::ADDR_BUF, {OK, 24'h0, b});
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h088});
    // second frame while end_flag still set
    peer.arm(a);
    wr(mmssu_pkg::ADDR_CTRL, 32'h0A8, OK);
    peer.burst(8);
    repeat (10) @(posedge clk_i);
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h08C});
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h08C});
    rd(mmssu_pkg::ADDR_STAT, {OK, 32'h3});
    wr(mmssu_pkg::ADDR_CTRL, 32'h080, OK);
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h080});
    // clock fall while idle
    peer.burst(1);
    repeat (10) @(posedge clk_i);
    rd(mmssu_pkg::ADDR_CTRL, {OK, 32'h084});
    report_and_stop;
  end
endmodule
